// *** core/gsq_dev.sv ***
`default_nettype none

module gsq_dev #(
   parameter int unsigned GAP_TICKS = gsq_pkg::SEQ_GAP_TICKS
) (
   input  wire logic   clock,
   input  wire logic   rst,
   gsq_if.dev          lnk,
   output logic        sync_stop,
   output logic        gear_rst,
   output logic        eclk_en,
   output logic        div_en,
   output logic [3:0]  site_gear,
   output logic [3:0]  site_plain,
   output logic [1:0]  bridge_src,
   output logic        bridge_shared
);

   typedef enum logic [2:0] {
      ST_STOP    = 3'h0,
      ST_HOLD    = 3'h1,
      ST_RELRST  = 3'h3,
      ST_RELSTOP = 3'h2,
      ST_READY   = 3'h6
   } gsq_state_e;

   localparam int unsigned CNT_W = $clog2(GAP_TICKS + 1);
   localparam logic [CNT_W-1:0] GAP = CNT_W'(GAP_TICKS);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

   gsq_state_e           st_q;
   gsq_state_e           st_d;
   logic [CNT_W-1:0]     cnt_q;
   logic [CNT_W-1:0]     cnt_d;
   logic                 stop_q;
   logic                 stop_d;
   logic                 rst_q;
   logic                 rst_d;
   logic                 ready_q;
   logic                 ready_d;
   logic                 ecen_q;
   logic                 ecen_d;
   gsq_pkg::gsq_mode_e   mode_q;
   gsq_pkg::gsq_mode_e   mode_d;
   logic                 pair_q;
   logic                 pair_d;
   logic                 bad;
   logic [3:0]           gear_d;
   logic [3:0]           gear_q;
   logic [3:0]           plain_d;
   logic [3:0]           plain_q;
   logic                 err_q;
   logic [gsq_pkg::DIV_W-1:0] ratio;
   logic [gsq_pkg::DIV_W-1:0] div_q;
   logic [gsq_pkg::DIV_W-1:0] div_d;
   logic                 den_q;
   logic                 den_d;
   logic [1:0]           bsrc_q;
   logic [1:0]           bsrc_d;
   logic                 bsh_q;
   logic                 bsh_d;

   // site allocation from latched mode and pair
   always_comb begin
      gear_d  = gsq_pkg::SITES_NONE;
      plain_d = gsq_pkg::SITES_ALL;
      bad     = 1'b0;
      unique case (mode_q)
         gsq_pkg::GSQ_MODE_X1: begin
            gear_d  = gsq_pkg::SITES_NONE;
            plain_d = gsq_pkg::SITES_ALL;
         end
         gsq_pkg::GSQ_MODE_X2: begin
            if (pair_q) begin
               gear_d  = gsq_pkg::SITES_CD;
               plain_d = gsq_pkg::SITES_AB;
               bad     = !lnk.pair_present[1];
            end else begin
               gear_d  = gsq_pkg::SITES_AB;
               plain_d = gsq_pkg::SITES_CD;
               bad     = !lnk.pair_present[0];
            end
         end
         gsq_pkg::GSQ_MODE_X4,
         gsq_pkg::GSQ_MODE_X71: begin
            gear_d  = gsq_pkg::SITES_ALL;
            plain_d = gsq_pkg::SITES_CD;
            bad     = !lnk.pair_present[0];
         end
      endcase
   end

   // divide ratio per gearing mode
   always_comb begin
      unique case (mode_q)
         gsq_pkg::GSQ_MODE_X1:  ratio = gsq_pkg::DIV_X1;
         gsq_pkg::GSQ_MODE_X2:  ratio = gsq_pkg::DIV_X2;
         gsq_pkg::GSQ_MODE_X4:  ratio = gsq_pkg::DIV_X4;
         gsq_pkg::GSQ_MODE_X71: ratio = gsq_pkg::DIV_X71;
      endcase
   end

   // reset sequencer
   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      mode_d = mode_q;
      pair_d = pair_q;
      if (lnk.slow_tick && cnt_q != GAP) begin
         cnt_d = cnt_q + CNT_ONE;
      end
      if (st_q == ST_HOLD) begin
         mode_d = lnk.mode;
         pair_d = lnk.pair_sel;
      end
      if (lnk.hold_req || bad) begin
         unique case (st_q)
            ST_READY,
            ST_RELSTOP: st_d = ST_STOP;
            ST_RELRST:  st_d = ST_HOLD;
            ST_STOP:    st_d = (cnt_q == GAP) ? ST_HOLD : ST_STOP;
            ST_HOLD:    st_d = ST_HOLD;
            default:    st_d = ST_HOLD;
         endcase
      end else if (cnt_q == GAP) begin
         unique case (st_q)
            ST_STOP:    st_d = ST_HOLD;
            ST_HOLD:    st_d = ST_RELRST;
            ST_RELRST:  st_d = ST_RELSTOP;
            ST_RELSTOP: st_d = ST_READY;
            ST_READY:   st_d = ST_READY;
            default:    st_d = ST_HOLD;
         endcase
      end
      if (st_d != st_q || (st_q == ST_HOLD && lnk.hold_req)) begin
         cnt_d = '0;
      end
      stop_d  = (st_d != ST_RELSTOP) && (st_d != ST_READY);
      rst_d   = (st_d == ST_HOLD);
      ready_d = (st_d == ST_READY);
      ecen_d  = !stop_d;
   end

   // divider released by the same reset edge as gearing
   always_comb begin
      div_d = div_q;
      den_d = 1'b0;
      if (rst_q) begin
         div_d = '0;
      end else if (ecen_q) begin
         if (div_q == ratio - gsq_pkg::DIV_X1) begin
            div_d = '0;
            den_d = ecen_d;
         end else begin
            div_d = div_q + gsq_pkg::DIV_X1;
         end
      end
   end

   // bridge muxes
   always_comb begin
      bsrc_d = bsrc_q;
      bsh_d  = bsh_q;
      if (lnk.bridge_use) begin
         bsrc_d = lnk.bridge_sel;
         bsh_d  = (lnk.bridge_sel[0] == lnk.bridge_sel[1]);
      end else begin
         bsrc_d = 2'h0;
         bsh_d  = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         st_q    <= ST_HOLD;
         cnt_q   <= '0;
         stop_q  <= 1'b1;
         rst_q   <= 1'b1;
         ready_q <= 1'b0;
         ecen_q  <= 1'b0;
         mode_q  <= gsq_pkg::GSQ_MODE_X1;
         pair_q  <= 1'b0;
         gear_q  <= gsq_pkg::SITES_NONE;
         plain_q <= gsq_pkg::SITES_ALL;
         err_q   <= 1'b0;
         div_q   <= '0;
         den_q   <= 1'b0;
         bsrc_q  <= 2'h0;
         bsh_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         cnt_q   <= cnt_d;
         stop_q  <= stop_d;
         rst_q   <= rst_d;
         ready_q <= ready_d;
         ecen_q  <= ecen_d;
         mode_q  <= mode_d;
         pair_q  <= pair_d;
         gear_q  <= gear_d;
         plain_q <= plain_d;
         err_q   <= bad;
         div_q   <= div_d;
         den_q   <= den_d;
         bsrc_q  <= bsrc_d;
         bsh_q   <= bsh_d;
      end
   end

   assign sync_stop     = stop_q;
   assign gear_rst      = rst_q;
   assign eclk_en       = ecen_q;
   assign div_en        = den_q;
   assign site_gear     = gear_q;
   assign site_plain    = plain_q;
   assign bridge_src    = bsrc_q;
   assign bridge_shared = bsh_q;
   assign lnk.seq_ready = ready_q;
   assign lnk.alloc_err = err_q;

endmodule // gsq_dev

`default_nettype wire

// *** core/gsq_host.sv ***
`default_nettype none

module gsq_host #(
   parameter int unsigned SLOW_DIV = gsq_pkg::SLOW_DIV
) (
   input  wire logic                clock,
   input  wire logic                rst,
   input  wire logic                reset_in,
   input  wire logic                is_rx,
   input  wire logic                loopback,
   input  wire logic                tx_done,
   input  wire gsq_pkg::gsq_mode_e  mode,
   input  wire logic                pair_sel,
   input  wire logic [1:0]          pair_present,
   input  wire logic                bridge_req,
   input  wire logic [1:0]          bridge_sel,
   gsq_if.host                      lnk,
   output logic                     ready,
   output logic                     alloc_err,
   output logic                     bridge_refused
);

   localparam int unsigned TW = $clog2(SLOW_DIV);
   localparam logic [TW-1:0] TLAST = TW'(SLOW_DIV - 1);
   localparam logic [TW-1:0] TONE  = TW'(1);

   logic                rs1_q;
   logic                rs2_q;
   logic [TW-1:0]       tc_q;
   logic [TW-1:0]       tc_d;
   logic                tick_q;
   logic                tick_d;
   logic                hold_q;
   logic                hold_d;
   logic                no_br;
   logic                bu_q;
   logic                bu_d;
   logic                rdy_q;
   logic                err_q;
   logic                ref_q;
   gsq_pkg::gsq_mode_e  mode_q;
   logic                pair_q;
   logic [1:0]          pres_q;
   logic [1:0]          bsel_q;

   // slow tick, strictly slower than the edge clock
   always_comb begin
      tick_d = 1'b0;
      tc_d   = tc_q + TONE;
      if (tc_q == TLAST) begin
         tc_d   = '0;
         tick_d = 1'b1;
      end
   end

   // hold the sequence while reset or waiting on transmit
   always_comb begin
      hold_d = rs2_q
             || (loopback && is_rx && !tx_done);
      no_br  = is_rx && (mode == gsq_pkg::GSQ_MODE_X2
                      || mode == gsq_pkg::GSQ_MODE_X4);
      bu_d   = bridge_req && !no_br;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rs1_q  <= 1'b1;
         rs2_q  <= 1'b1;
         tc_q   <= '0;
         tick_q <= 1'b0;
         hold_q <= 1'b1;
         bu_q   <= 1'b0;
         rdy_q  <= 1'b0;
         err_q  <= 1'b0;
         ref_q  <= 1'b0;
         mode_q <= gsq_pkg::GSQ_MODE_X1;
         pair_q <= 1'b0;
         pres_q <= 2'h0;
         bsel_q <= 2'h0;
      end else begin
         rs1_q  <= reset_in;
         rs2_q  <= rs1_q;
         tc_q   <= tc_d;
         tick_q <= tick_d;
         hold_q <= hold_d;
         bu_q   <= bu_d;
         rdy_q  <= lnk.seq_ready && !hold_q;
         err_q  <= lnk.alloc_err;
         ref_q  <= bridge_req && no_br;
         mode_q <= mode;
         pair_q <= pair_sel;
         pres_q <= pair_present;
         bsel_q <= bridge_sel;
      end
   end

   assign lnk.hold_req     = hold_q;
   assign lnk.slow_tick    = tick_q;
   assign lnk.mode         = mode_q;
   assign lnk.pair_sel     = pair_q;
   assign lnk.pair_present = pres_q;
   assign lnk.bridge_use   = bu_q;
   assign lnk.bridge_sel   = bsel_q;
   assign ready            = rdy_q;
   assign alloc_err        = err_q;
   assign bridge_refused   = ref_q;

endmodule // gsq_host

`default_nettype wire

// *** core/gsq_if.sv ***
`default_nettype none

interface gsq_if;
   logic                  hold_req;
   logic                  slow_tick;
   gsq_pkg::gsq_mode_e    mode;
   logic                  pair_sel;
   logic [1:0]            pair_present;
   logic                  bridge_use;
   logic [1:0]            bridge_sel;
   logic                  seq_ready;
   logic                  alloc_err;

   modport dev (
      input  hold_req,
      input  slow_tick,
      input  mode,
      input  pair_sel,
      input  pair_present,
      input  bridge_use,
      input  bridge_sel,
      output seq_ready,
      output alloc_err
   );

   modport host (
      output hold_req,
      output slow_tick,
      output mode,
      output pair_sel,
      output pair_present,
      output bridge_use,
      output bridge_sel,
      input  seq_ready,
      input  alloc_err
   );
endinterface : gsq_if

`default_nettype wire

// *** core/gsq_pkg.sv ***
// How it works
// - x2 takes one site pair, second site lost
// - x4 or 7:1 takes four sites, first site
// - x4 or 7:1 needs first pin pair present
// - other pair stays plain or x1 gearing
// - two bridge muxes, each picks one of two
// - one source may feed top and bottom
// - no bridge for x2 or x4 receive
// - divider and gearing start same edge cycle
// - high ratio needs synchronizer plus reset sequence
// - reset and stop edges two cycles apart
// - loopback receive waits for transmit done
// - sequence timed by clock slower than edge
// - sequence built explicitly in logic
// - ready raised after sequence, held while running
// - reset input asynchronous, restarts whole sequence
`default_nettype none

package gsq_pkg;

   typedef enum logic [1:0] {
      GSQ_MODE_X1  = 2'h0,
      GSQ_MODE_X2  = 2'h1,
      GSQ_MODE_X4  = 2'h2,
      GSQ_MODE_X71 = 2'h3
   } gsq_mode_e;

   localparam int unsigned SITES         = 4;
   localparam int unsigned SEQ_GAP_TICKS = 2;
   localparam int unsigned SLOW_DIV      = 4;
   localparam int unsigned DIV_W         = 3;

   localparam logic [DIV_W-1:0] DIV_X1  = 3'h1;
   localparam logic [DIV_W-1:0] DIV_X2  = 3'h2;
   localparam logic [DIV_W-1:0] DIV_X4  = 3'h4;
   localparam logic [DIV_W-1:0] DIV_X71 = 3'h7;

   localparam logic [3:0] SITES_NONE = 4'h0;
   localparam logic [3:0] SITES_ALL  = 4'hF;
   localparam logic [3:0] SITES_AB   = 4'h3;
   localparam logic [3:0] SITES_CD   = 4'hC;

endpackage : gsq_pkg

`default_nettype wire

// *** dv/gsq_assertions.sv ***
`default_nettype none

module gsq_assertions (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic       hold_req,
   input wire logic       seq_ready,
   input wire logic       alloc_err,
   input wire logic       bridge_use,
   input wire logic [1:0] bridge_sel,
   input wire logic       sync_stop,
   input wire logic       gear_rst,
   input wire logic       eclk_en,
   input wire logic       div_en,
   input wire logic [1:0] bridge_src
);
   logic [5:0] wait_q;
   logic [5:0] wait_d;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // cycles spent released but not ready
   always_comb begin
      wait_d = 6'h00;
      if (!hold_req && !alloc_err && !seq_ready && wait_q != 6'h3F)
         wait_d = wait_q + 6'h01;
   end

   always_ff @(posedge clock) begin
      wait_q <= rst ? 6'h00 : wait_d;
   end

   a_stop_leads_rst:
      assert property ($rose(gear_rst) |-> $past(sync_stop, 4))
      else $error("gear reset rose without stop held before");
   a_rst_fall_gap:
      assert property ($fell(gear_rst) |-> sync_stop [*4])
      else $error("stop moved too soon after gear reset fell");
   a_stop_fall_gap:
      assert property ($fell(sync_stop) |-> !$past(gear_rst, 4))
      else $error("stop fell too soon after gear reset");
   a_ready_clean:
      assert property (seq_ready |-> !sync_stop && !gear_rst && eclk_en)
      else $error("ready while stopped or in reset");
   a_eclk_gated:
      assert property (sync_stop |-> !eclk_en)
      else $error("edge clock running while stopped");
   a_hold_drops:
      assert property (hold_req || alloc_err |=> !seq_ready)
      else $error("ready kept during hold or fault");
   a_ready_bound:
      assert property (wait_q < 6'h28)
      else $error("sequence did not finish in time");
   a_div_running:
      assert property (div_en |-> eclk_en && !gear_rst)
      else $error("divider pulse outside run");
   a_div_not_first:
      assert property ($rose(eclk_en) |-> !div_en)
      else $error("divider pulse on first edge cycle");
   a_bridge_copy:
      assert property (bridge_src ==
         ($past(bridge_use) ? $past(bridge_sel) : 2'h0))
      else $error("bridge select not copied");
endmodule // gsq_assertions

`default_nettype wire

// *** dv/gsq_bench.sv ***
`default_nettype none

module gsq_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic               clock = 1'b0;
   logic               rst = 1'b1;
   logic               reset_in = 1'b1;
   logic               is_rx = 1'b0;
   logic               loopback = 1'b0;
   logic               tx_done = 1'b0;
   gsq_pkg::gsq_mode_e mode = gsq_pkg::GSQ_MODE_X1;
   logic               pair_sel = 1'b0;
   logic [1:0]         pair_present = 2'h3;
   logic               bridge_req = 1'b0;
   logic [1:0]         bridge_sel = 2'h0;
   logic               ready, alloc_err, bridge_refused;
   logic               sync_stop, gear_rst, eclk_en, div_en;
   logic [3:0]         site_gear, site_plain;
   logic [1:0]         bridge_src;
   logic               bridge_shared;
   localparam int unsigned DIV_WIN = 28;
   int                 mismatches = 0;
   int                 comparisons = 0;
   logic [31:0]        rng = 32'h0000003E;

   gsq_if lnk ();
   always #4 clock = ~clock;

   gsq_host u_gsq_host (.clock(clock), .rst(rst), .reset_in(reset_in),
      .is_rx(is_rx), .loopback(loopback), .tx_done(tx_done), .mode(mode),
      .pair_sel(pair_sel), .pair_present(pair_present),
      .bridge_req(bridge_req), .bridge_sel(bridge_sel), .lnk(lnk),
      .ready(ready), .alloc_err(alloc_err), .bridge_refused(bridge_refused));
   gsq_dev u_gsq_dev (.clock(clock), .rst(rst), .lnk(lnk),
      .sync_stop(sync_stop), .gear_rst(gear_rst), .eclk_en(eclk_en),
      .div_en(div_en), .site_gear(site_gear), .site_plain(site_plain),
      .bridge_src(bridge_src), .bridge_shared(bridge_shared));
   gsq_assertions u_gsq_assertions (.clock(clock), .rst(rst),
      .hold_req(lnk.hold_req), .seq_ready(lnk.seq_ready),
      .alloc_err(lnk.alloc_err), .bridge_use(lnk.bridge_use),
      .bridge_sel(lnk.bridge_sel), .sync_stop(sync_stop),
      .gear_rst(gear_rst), .eclk_en(eclk_en), .div_en(div_en),
      .bridge_src(bridge_src));

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // {fault, gearing sites, plain sites}
   function automatic logic [8:0] exp_place(input logic [1:0] m,
         input logic ps, input logic [1:0] pp);
      if (m == 2'h0) return {1'b0, 4'h0, 4'hF};
      if (m == 2'h1) return ps ? {!pp[1], 4'hC, 4'h3} : {!pp[0], 4'h3, 4'hC};
      return {!pp[0], 4'hF, 4'hC};
   endfunction

   // divided clock ratio per mode
   function automatic int unsigned exp_ratio(input logic [1:0] m);
      if (m == 2'h0) return gsq_pkg::DIV_X1;
      if (m == 2'h1) return gsq_pkg::DIV_X2;
      if (m == 2'h2) return gsq_pkg::DIV_X4;
      return gsq_pkg::DIV_X71;
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic run_cfg(input logic [1:0] m, input logic ps,
         input logic [1:0] pp, input logic rx, input logic br,
         input logic [1:0] bs);
      logic [8:0] e;
      logic       rf;
      int unsigned np;
      e = exp_place(m, ps, pp);
      rf = br && rx && (m == 2'h1 || m == 2'h2);
      reset_in = 1'b1;
      mode = gsq_pkg::gsq_mode_e'(m);
      pair_sel = ps;
      pair_present = pp;
      is_rx = rx;
      bridge_req = br;
      bridge_sel = bs;
      step(24);
      chk("ready_held", 8'h00, ready);
      reset_in = 1'b0;
      for (int i = 0; i < 200 && ready !== 1'b1 && alloc_err !== 1'b1; i++)
         step(1);
      step(4);
      chk("alloc_err", e[8], alloc_err);
      chk("ready", !e[8], ready);
      if (!e[8]) begin
         chk("site_gear", e[7:4], site_gear);
         chk("site_plain", e[3:0], site_plain);
         chk("run_state", 8'h01, {sync_stop, gear_rst, eclk_en});
         np = 0;
         for (int i = 0; i < DIV_WIN; i++) begin
            step(1);
            if (div_en === 1'b1)
               np++;
         end
         chk("div_pulses", 8'(DIV_WIN / exp_ratio(m)), 8'(np));
      end
      chk("refused", rf, bridge_refused);
      chk("bridge_src", (br && !rf) ? bs : 2'h0, bridge_src);
      chk("bridge_shared", br && !rf && (bs[0] == bs[1]), bridge_shared);
   endtask

   task automatic complete_run;
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      mismatches++;
      complete_run;
   end

   initial begin
      step(6);
      rst = 1'b0;
      step(2);
      for (int k = 0; k < 8; k++)
         run_cfg(k[2:1], k[0], 2'h3, 1'b0, 1'b0, 2'h0);
      run_cfg(2'h2, 1'b0, 2'h2, 1'b0, 1'b0, 2'h0);
      run_cfg(2'h3, 1'b0, 2'h1, 1'b0, 1'b0, 2'h0);
      run_cfg(2'h1, 1'b1, 2'h1, 1'b0, 1'b0, 2'h0);
      run_cfg(2'h1, 1'b0, 2'h3, 1'b1, 1'b1, 2'h2);
      run_cfg(2'h3, 1'b0, 2'h3, 1'b1, 1'b1, 2'h1);
      run_cfg(2'h2, 1'b0, 2'h3, 1'b0, 1'b1, 2'h3);
      repeat (12) begin
         rng = xs(rng);
         run_cfg(rng[1:0], rng[2], rng[4:3], rng[5], rng[6], rng[8:7]);
      end
      // receive end waits for transmit end
      reset_in = 1'b1;
      is_rx = 1'b1;
      loopback = 1'b1;
      bridge_req = 1'b0;
      mode = gsq_pkg::GSQ_MODE_X71;
      pair_present = 2'h3;
      step(24);
      reset_in = 1'b0;
      step(150);
      chk("ready_loop_wait", 8'h00, ready);
      tx_done = 1'b1;
      step(60);
      chk("ready_loop_go", 8'h01, ready);
      rst = 1'b1;
      step(2);
      chk("in_rst", 8'h06, {sync_stop, gear_rst, ready});
      rst = 1'b0;
      step(80);
      chk("ready_again", 8'h01, ready);
      complete_run;
   end
endmodule // gsq_bench

`default_nettype wire
